// [pkg/rpt_pkg.sv]
package rpt_pkg;

   // ----------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------
   // Indices are word numbers; the bus sees four times the index
   localparam logic [5:0] IDX_STATUS      = 6'h02;
   localparam logic [5:0] IDX_SYS_CTRL    = 6'h11;
   localparam logic [5:0] IDX_PLL_CFG1    = 6'h17;
   localparam logic [5:0] IDX_PLL_CFG2    = 6'h18;
   localparam logic [5:0] IDX_CLK_CFG     = 6'h1A;
   localparam logic [5:0] IDX_BIOZ_CFG    = 6'h20;
   localparam logic [7:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};
   localparam logic [7:0] ADDR_SYS_CTRL   = {IDX_SYS_CTRL, 2'b00};
   localparam logic [7:0] ADDR_PLL_CFG1   = {IDX_PLL_CFG1, 2'b00};
   localparam logic [7:0] ADDR_PLL_CFG2   = {IDX_PLL_CFG2, 2'b00};
   localparam logic [7:0] ADDR_CLK_CFG    = {IDX_CLK_CFG, 2'b00};
   localparam logic [7:0] ADDR_BIOZ_CFG   = {IDX_BIOZ_CFG, 2'b00};

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int STAT_FLOCK_BIT   = 3;
   localparam int STAT_PLOCK_BIT   = 2;
   localparam int SYS_SHUTDOWN_BIT = 1;
   localparam int SYS_RESET_BIT    = 0;
   localparam int PLL_EN_BIT       = 0;
   localparam int PLL_DIV_HI_MSB   = 7;
   localparam int PLL_DIV_HI_LSB   = 6;
   localparam int CLK_REFSEL_BIT   = 6;
   localparam int CLK_FREQSEL_BIT  = 5;
   localparam int CLK_TRIM_MSB     = 4;
   localparam int BIOZ_REF_BIT     = 2;
   localparam int BIOZ_Q_BIT       = 1;
   localparam int BIOZ_I_BIT       = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_SYS_CTRL = 8'h00;
   localparam logic [7:0] RST_PLL_CFG1 = 8'h00;
   localparam logic [7:0] RST_PLL_CFG2 = 8'h00;
   localparam logic [7:0] RST_CLK_CFG  = 8'h00;
   localparam logic [7:0] RST_BIOZ_CFG = 8'h00;

   // ----------------------------------------
   // AXI responses
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Timing counts
   // ----------------------------------------
   localparam int CLOCK_HZ            = 20_000_000;
   localparam int FREQ_SETTLE_US      = 100;
   localparam int FREQ_SETTLE_CYCLES  = (CLOCK_HZ / 1_000_000) * FREQ_SETTLE_US;
   localparam int PHASE_LOCK_US       = 200;
   localparam int PHASE_LOCK_CYCLES   = (CLOCK_HZ / 1_000_000) * PHASE_LOCK_US;
   localparam int LOCK_CNT_W          = 13;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      RPT_PLL_OFF    = 2'b00,
      RPT_PLL_FLOCK  = 2'b01,
      RPT_PLL_PLOCK  = 2'b11
   } rpt_pll_state_type;

   typedef struct packed {
      logic       ref_external;
      logic       freq_choice;
      logic [4:0] trim;
   } rpt_clk_cfg_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } rpt_wreq_type;

endpackage : rpt_pkg

// [logic/rpt_timing_ctrl.sv]
`timescale 1ns/10ps
// What this block does
// - Select bit 0: internal oscillator feeds reference
// - Select bit 1: external clock pin feeds reference
// - Two oscillators, frequency bit picks one
// - Five-bit trim field adjusts slow oscillator
// - Multiplier is ten-bit divider plus one
// - Status shows frequency lock and phase lock
// - Reset bit returns registers to defaults
module rpt_timing_ctrl
   import rpt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        external_ref_clock_in,
   input  wire logic        osc_clock_32k0,
   input  wire logic        osc_clock_32k768,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             pll_ref_clock,
   output logic             internal_slow_osc_clock,
   output logic [4:0]       osc_trim,
   output logic [9:0]       pll_multiplier_m,
   output logic             pll_enable,
   output logic             shutdown_request,
   output logic             measurement_reference_on,
   output logic             channel_q_on,
   output logic             channel_i_on
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0]        sys_ctrl;
   logic [7:0]        pll_cfg1;
   logic [7:0]        pll_cfg2;
   rpt_clk_cfg_type   clk_cfg;
   logic [7:0]        bioz_cfg;
   logic              soft_reset;
   logic [9:0]        pll_feedback_divider;
   logic              frequency_locked_flag;
   logic              phase_locked_flag;
   rpt_pll_state_type pll_state;
   rpt_pll_state_type next_pll_state;
   logic [LOCK_CNT_W-1:0] lock_count;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic         aw_held;
   logic         w_held;
   logic [7:0]   aw_addr;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         do_write;

   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == ADDR_STATUS) || (a == ADDR_SYS_CTRL) || (a == ADDR_PLL_CFG1)
                 || (a == ADDR_PLL_CFG2) || (a == ADDR_CLK_CFG) || (a == ADDR_BIOZ_CFG);
   endfunction : addr_mapped

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Only the low byte lane carries register data
   logic wr_low;
   assign wr_low = do_write && w_strb[0];
   assign soft_reset = wr_low && (aw_addr == ADDR_SYS_CTRL) && w_data[SYS_RESET_BIT];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sys_ctrl <= RST_SYS_CTRL;
         pll_cfg1 <= RST_PLL_CFG1;
         pll_cfg2 <= RST_PLL_CFG2;
         clk_cfg  <= rpt_clk_cfg_type'(RST_CLK_CFG[6:0]);
         bioz_cfg <= RST_BIOZ_CFG;
      end else if (soft_reset) begin
         // Every register back to default; reset bit self-clears
         sys_ctrl <= RST_SYS_CTRL;
         pll_cfg1 <= RST_PLL_CFG1;
         pll_cfg2 <= RST_PLL_CFG2;
         clk_cfg  <= rpt_clk_cfg_type'(RST_CLK_CFG[6:0]);
         bioz_cfg <= RST_BIOZ_CFG;
      end else if (wr_low) begin
         case (aw_addr)
            ADDR_SYS_CTRL: begin
               sys_ctrl <= {6'h00, w_data[SYS_SHUTDOWN_BIT], 1'b0};
            end
            ADDR_PLL_CFG1: begin
               pll_cfg1 <= w_data[7:0];
            end
            ADDR_PLL_CFG2: begin
               pll_cfg2 <= w_data[7:0];
            end
            ADDR_CLK_CFG: begin
               clk_cfg <= rpt_clk_cfg_type'(w_data[6:0]);
            end
            ADDR_BIOZ_CFG: begin
               bioz_cfg <= {5'h00, w_data[2:0]};
            end
            default: begin
            end
         endcase
      end
   end

   // Divider high bits in first register, low byte in second
   assign pll_feedback_divider = {pll_cfg1[PLL_DIV_HI_MSB:PLL_DIV_HI_LSB], pll_cfg2};

   // ----------------------------------------
   // Lock tracking
   // ----------------------------------------
   // Lock is modelled by a settle count; real lock comes from the analog loop
   always_comb begin
      next_pll_state = pll_state;
      case (pll_state)
         RPT_PLL_OFF: begin
            if (pll_cfg1[PLL_EN_BIT]) begin
               next_pll_state = RPT_PLL_FLOCK;
            end
         end
         RPT_PLL_FLOCK: begin
            if (!pll_cfg1[PLL_EN_BIT]) begin
               next_pll_state = RPT_PLL_OFF;
            end else if (lock_count == LOCK_CNT_W'(PHASE_LOCK_CYCLES - 1)) begin
               next_pll_state = RPT_PLL_PLOCK;
            end
         end
         RPT_PLL_PLOCK: begin
            if (!pll_cfg1[PLL_EN_BIT]) begin
               next_pll_state = RPT_PLL_OFF;
            end
         end
         default: begin
            next_pll_state = RPT_PLL_OFF;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pll_state <= RPT_PLL_OFF;
      end else begin
         pll_state <= next_pll_state;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lock_count <= '0;
      end else if (pll_state != RPT_PLL_FLOCK) begin
         lock_count <= '0;
      end else if (lock_count != LOCK_CNT_W'(PHASE_LOCK_CYCLES - 1)) begin
         lock_count <= lock_count + LOCK_CNT_W'(1);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frequency_locked_flag <= 1'b0;
         phase_locked_flag     <= 1'b0;
      end else if (next_pll_state == RPT_PLL_OFF) begin
         frequency_locked_flag <= 1'b0;
         phase_locked_flag     <= 1'b0;
      end else begin
         frequency_locked_flag <= frequency_locked_flag
            || (lock_count >= LOCK_CNT_W'(FREQ_SETTLE_CYCLES - 1));
         phase_locked_flag     <= (next_pll_state == RPT_PLL_PLOCK);
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   function automatic logic [7:0] read_mux(input logic [7:0] a);
      case (a)
         ADDR_STATUS: begin
            read_mux = {4'h0, frequency_locked_flag, phase_locked_flag, 2'b00};
         end
         ADDR_SYS_CTRL: read_mux = sys_ctrl;
         ADDR_PLL_CFG1: read_mux = pll_cfg1;
         ADDR_PLL_CFG2: read_mux = pll_cfg2;
         ADDR_CLK_CFG:  read_mux = {1'b0, clk_cfg};
         ADDR_BIOZ_CFG: read_mux = bioz_cfg;
         default:       read_mux = 8'h00;
      endcase
   endfunction : read_mux

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, read_mux(s_axi_araddr)};
         s_axi_rresp   <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Clock selection and outputs
   // ----------------------------------------
   // Clocks are sampled as data; a real part would use a glitch-free mux
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         internal_slow_osc_clock <= 1'b0;
         pll_ref_clock           <= 1'b0;
      end else begin
         internal_slow_osc_clock <= clk_cfg.freq_choice ? osc_clock_32k768
                                                        : osc_clock_32k0;
         pll_ref_clock <= clk_cfg.ref_external ? external_ref_clock_in
                        : (clk_cfg.freq_choice ? osc_clock_32k768 : osc_clock_32k0);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         osc_trim                 <= 5'h00;
         pll_multiplier_m         <= 10'h001;
         pll_enable               <= 1'b0;
         shutdown_request         <= 1'b0;
         measurement_reference_on <= 1'b0;
         channel_q_on             <= 1'b0;
         channel_i_on             <= 1'b0;
      end else begin
         osc_trim                 <= clk_cfg.trim;
         pll_multiplier_m         <= pll_feedback_divider + 10'h001;
         pll_enable               <= pll_cfg1[PLL_EN_BIT];
         shutdown_request         <= sys_ctrl[SYS_SHUTDOWN_BIT];
         measurement_reference_on <= bioz_cfg[BIOZ_REF_BIT];
         channel_q_on             <= bioz_cfg[BIOZ_Q_BIT];
         channel_i_on             <= bioz_cfg[BIOZ_I_BIT];
      end
   end

endmodule : rpt_timing_ctrl

// [dv/rpt_timing_ctrl_chk.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module rpt_timing_ctrl_chk
   import rpt_pkg::*;
(
   input logic        clock,
   input logic        rst,
   input logic        external_ref_clock_in,
   input logic        osc_clock_32k0,
   input logic        osc_clock_32k768,
   input logic [7:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0]  s_axi_wstrb,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic [7:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        pll_ref_clock,
   input logic        internal_slow_osc_clock,
   input logic [4:0]  osc_trim,
   input logic [9:0]  pll_multiplier_m,
   input logic        pll_enable,
   input logic        measurement_reference_on
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   localparam int FL = FREQ_SETTLE_CYCLES;
   localparam int PL = PHASE_LOCK_CYCLES;
   logic [12:0] en_cnt;
   logic        stat_rd;
   // Saturates so a long enable never wraps back under the lock times
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         en_cnt <= 13'h0000;
      end else if (!pll_enable) begin
         en_cnt <= 13'h0000;
      end else if (en_cnt != 13'h1FFF) begin
         en_cnt <= en_cnt + 13'h0001;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_rd <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         stat_rd <= (s_axi_araddr == ADDR_STATUS);
      end
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_soft_reset;
      s_wr_taken ##0 (s_axi_awaddr == ADDR_SYS_CTRL && s_axi_wstrb[0] && s_axi_wdata[0]);
   endsequence
   property p_ref_source;
      !$past(rst) && pll_ref_clock |->
         $past(external_ref_clock_in | osc_clock_32k0 | osc_clock_32k768);
   endproperty
   a_ref_source: assert property (p_ref_source)
      else $error("reference high with no source high");
   property p_slow_osc;
      !$past(rst) && internal_slow_osc_clock |-> $past(osc_clock_32k0 | osc_clock_32k768);
   endproperty
   a_slow_osc: assert property (p_slow_osc)
      else $error("slow oscillator high with no oscillator high");
   property p_soft_reset;
      s_soft_reset |-> ##[1:3] (osc_trim == 5'h00 && pll_multiplier_m == 10'h001
                                && !pll_enable && !measurement_reference_on);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset left outputs off default");
   property p_lock_clear;
      !pll_enable && !$past(pll_enable) && $rose(s_axi_rvalid) && stat_rd
         |-> s_axi_rdata[3:2] == 2'b00;
   endproperty
   a_lock_clear: assert property (p_lock_clear)
      else $error("lock flag set while pll off");
   property p_frequency_locked_flag;
      $rose(s_axi_rvalid) && stat_rd |-> (en_cnt < FL - 4) ? !s_axi_rdata[3] :
         ((en_cnt > FL + 4) ? s_axi_rdata[3] : 1'b1);
   endproperty
   a_frequency_locked_flag: assert property (p_frequency_locked_flag)
      else $error("frequency lock flag at wrong time");
   property p_phase_lock;
      $rose(s_axi_rvalid) && stat_rd |-> (en_cnt < PL - 4) ? !s_axi_rdata[2] :
         ((en_cnt > PL + 4) ? s_axi_rdata[2] : 1'b1);
   endproperty
   a_phase_lock: assert property (p_phase_lock)
      else $error("phase lock flag at wrong time");
   property p_wr_answer;
      s_wr_taken |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read data late");
   property p_wr_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_busy: assert property (p_wr_busy)
      else $error("write taken while response pending");
endmodule : rpt_timing_ctrl_chk

bind rpt_timing_ctrl rpt_timing_ctrl_chk chk_u (.*);

// [dv/test_ref_clock_pll_timing_control.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// Register level regression
// ------------------------------------------------------------
module test_ref_clock_pll_timing_control
   import rpt_pkg::*;
;
   logic        clock, rst, ext_in, osc_a, osc_b;
   logic [7:0]  aw_addr, ar_addr;
   logic [31:0] w_data, r_data;
   logic [3:0]  w_strb, tick;
   logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
   logic        ar_valid, ar_ready, r_valid, r_ready;
   logic [1:0]  b_resp, r_resp, pick;
   logic        ref_clk, slow_osc, pll_en, shut_req, ref_on, ch_q, ch_i;
   logic [4:0]  trim;
   logic [9:0]  m_val;
   logic [2:0]  src_q;
   int          failures, compares, cycles;
   localparam logic [7:0] reg_list [6] = '{ADDR_STATUS, ADDR_SYS_CTRL, ADDR_PLL_CFG1,
                                           ADDR_PLL_CFG2, ADDR_CLK_CFG, ADDR_BIOZ_CFG};
   rpt_timing_ctrl dut_u (.clock(clock), .rst(rst), .external_ref_clock_in(ext_in),
      .osc_clock_32k0(osc_a), .osc_clock_32k768(osc_b), .s_axi_awaddr(aw_addr),
      .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
      .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
      .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
      .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
      .s_axi_rready(r_ready), .pll_ref_clock(ref_clk), .internal_slow_osc_clock(slow_osc),
      .osc_trim(trim), .pll_multiplier_m(m_val), .pll_enable(pll_en),
      .shutdown_request(shut_req), .measurement_reference_on(ref_on),
      .channel_q_on(ch_q), .channel_i_on(ch_i));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Sources never share a pattern, so a wrong pick shows within 8 cycles
   always @(posedge clock) begin
      tick <= tick + 4'h1;
      src_q <= {ext_in, osc_b, osc_a};
      ext_in <= ~ext_in;
      osc_a <= tick[1];
      osc_b <= ~tick[2];
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      @(posedge clock);
      aw_addr <= a;
      w_data <= d;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clock);
         if (aw_valid && aw_ready) begin
            aw_ok = 1'b1;
            aw_valid <= 1'b0;
         end
         if (w_valid && w_ready) begin
            w_ok = 1'b1;
            w_valid <= 1'b0;
         end
      end
      do @(posedge clock); while (!b_valid);
      b_ready <= 1'b0;
      chk("write resp", 32'(er), 32'(b_resp));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clock);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do @(posedge clock); while (!ar_ready);
      ar_valid <= 1'b0;
      do @(posedge clock); while (!r_valid);
      r_ready <= 1'b0;
      chk($sformatf("read %h", a), e, r_data);
      chk("read resp", 32'(er), 32'(r_resp));
   endtask : rd
   task automatic src_chk(input logic ext, output logic pk);
      int h_a;
      int h_b;
      h_a = 0;
      h_b = 0;
      repeat (8) begin
         @(negedge clock);
         h_a += int'(slow_osc === src_q[0]);
         h_b += int'(slow_osc === src_q[1]);
         chk("ref clock", 32'(ext ? src_q[2] : slow_osc), 32'(ref_clk));
      end
      pk = (h_b == 8);
      chk("osc follows", 32'h1, 32'((h_a == 8) != (h_b == 8)));
   endtask : src_chk
   task automatic note(input string n);
      $display("test %s finished", n);
   endtask : note
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   initial begin
      rst = 1'b1;
      {ext_in, osc_a, osc_b, tick, src_q, cycles, failures, compares} = '0;
      {aw_addr, ar_addr, w_data, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
      w_strb = 4'hF;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      foreach (reg_list[i]) rd(reg_list[i], 32'h0, RESP_OKAY);
      chk("multiplier", 32'h001, 32'(m_val));
      note("reset values");
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CLK_CFG, 32'(k * 39), RESP_OKAY);
         repeat (2) @(posedge clock);
         src_chk(k[1], pick[k[0]]);
         chk("trim", 32'(k * 7), 32'(trim));
         rd(ADDR_CLK_CFG, 32'(k * 39), RESP_OKAY);
      end
      chk("osc choice", 32'h1, 32'(pick[0] != pick[1]));
      note("clock sources");
      wr(ADDR_PLL_CFG2, 32'hAA, RESP_OKAY);
      wr(ADDR_PLL_CFG1, 32'h40, RESP_OKAY);
      @(negedge clock);
      chk("m low end", 32'h1AB, 32'(m_val));
      wr(ADDR_PLL_CFG2, 32'h6A, RESP_OKAY);
      wr(ADDR_PLL_CFG1, 32'hC0, RESP_OKAY);
      @(negedge clock);
      chk("m high end", 32'h36B, 32'(m_val));
      note("divider");
      wr(ADDR_BIOZ_CFG, 32'h4, RESP_OKAY);
      wr(ADDR_PLL_CFG1, 32'hC1, RESP_OKAY);
      rd(ADDR_STATUS, 32'h0, RESP_OKAY);
      repeat (2100) @(posedge clock);
      rd(ADDR_STATUS, 32'h8, RESP_OKAY);
      repeat (2000) @(posedge clock);
      rd(ADDR_STATUS, 32'hC, RESP_OKAY);
      wr(ADDR_BIOZ_CFG, 32'h7, RESP_OKAY);
      @(negedge clock);
      chk("channels", 32'hF, 32'({pll_en, ref_on, ch_q, ch_i}));
      wr(ADDR_BIOZ_CFG, 32'h4, RESP_OKAY);
      wr(ADDR_PLL_CFG1, 32'hC0, RESP_OKAY);
      rd(ADDR_STATUS, 32'h0, RESP_OKAY);
      note("pll lock");
      wr(ADDR_SYS_CTRL, 32'h2, RESP_OKAY);
      @(negedge clock);
      chk("shutdown on", 32'h1, 32'(shut_req));
      wr(ADDR_SYS_CTRL, 32'h0, RESP_OKAY);
      @(negedge clock);
      chk("shutdown off", 32'h0, 32'(shut_req));
      note("shutdown");
      rd(8'h04, 32'h0, RESP_SLVERR);
      wr(8'h04, 32'hFF, RESP_SLVERR);
      @(posedge clock);
      w_strb <= 4'h0;
      wr(ADDR_CLK_CFG, 32'h1F, RESP_OKAY);
      @(posedge clock);
      w_strb <= 4'hF;
      rd(ADDR_CLK_CFG, 32'h75, RESP_OKAY);
      note("refusals");
      wr(ADDR_CLK_CFG, 32'h1F, RESP_OKAY);
      repeat (20000) @(posedge clock);
      wr(ADDR_SYS_CTRL, 32'h1, RESP_OKAY);
      @(negedge clock);
      chk("defaults", 32'h1, 32'({trim, ref_on, pll_en, m_val}));
      foreach (reg_list[i]) rd(reg_list[i], 32'h0, RESP_OKAY);
      note("soft reset");
      end_of_test();
   end
endmodule : test_ref_clock_pll_timing_control
